// ==== core/sart_map.svh ====
`ifndef SART_MAP_SVH
`define SART_MAP_SVH

// register byte offsets on the wishbone bus
`define SART_ADR_ROUTE 4'h0
`define SART_ADR_STATUS 4'h4

// route register fields and reset value
`define SART_ROUTE_RST 16'h0000
`define SART_SEL_LSB 0
`define SART_SEL_MSB 3
`define SART_SRC_BIT 4
`define SART_SEL_OFF 4'h0

// status register fields
`define SART_ST_LEVEL_MSB 4
`define SART_ST_UNDERRUN 8
`define SART_ST_ACTIVE 9

// stream and tdm framing
`define SART_FRAME_W 59
`define SART_FIFO_DEPTH 16
`define SART_PORTS 4
`define SART_LAST_BIT 8'hff
`define SART_PAD 8'h00

`endif

// ==== core/sart_pkg.sv ====
package sart_pkg;

  // one decoded receiver frame as it waits in the fifo
  typedef struct packed {
    logic [23:0] left_audio;
    logic [23:0] right_audio;
    logic [3:0] left_pvuc;
    logic [3:0] right_pvuc;
    logic compr_type;
    logic audio_type;
    logic block_start;
  } sart_frame_t;

  typedef enum logic [0:0] {
    SER_IDLE = 1'b0,
    SER_RUN = 1'b1
  } sart_ser_state_t;

endpackage

// ==== core/sart_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
module sart_fifo
#(
  parameter int W = 8,
  parameter int D = 16
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic ce,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data,
  // fill level
  output logic [$clog2(D):0] level
);
  localparam int AW = $clog2(D);
  localparam logic [AW:0] FULL = (AW+1)'(D);
  localparam logic [AW-1:0] LAST = (AW)'(D - 1);

  logic [W-1:0] mem [D];
  logic [AW-1:0] wptr, rptr, next_wptr, next_rptr;
  logic [AW:0] count, next_count;
  logic wr, rd;

  always_comb
  begin
    in_ready = (count != FULL);
    out_valid = (count != '0);
    wr = in_valid & in_ready;
    rd = out_valid & out_ready;
    next_wptr = wr ? ((wptr == LAST) ? '0 : wptr + 1'b1) : wptr;
    next_rptr = rd ? ((rptr == LAST) ? '0 : rptr + 1'b1) : rptr;
    next_count = count;
    if (wr && !rd)
      next_count = count + 1'b1;
    else if (rd && !wr)
      next_count = count - 1'b1;
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
    end
    else if (ce)
    begin
      wptr <= next_wptr;
      rptr <= next_rptr;
      count <= next_count;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (ce && wr)
      mem[wptr] <= in_data;
  end

  assign out_data = mem[rptr];
  assign level = count;

  a_no_overfill: assert property (@(posedge sys_clk) disable iff (!resetn)
    (count == FULL) |-> !in_ready)
    else $error("fifo accepts data while full");

  c_fifo_full: cover property (@(posedge sys_clk) disable iff (!resetn) count == FULL);
endmodule
`default_nettype wire

// ==== core/sart_tdm_ser.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sart_map.svh"
module sart_tdm_ser
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic ce,
  // selected serial clocks, as sampled events
  input wire logic bit_tick,
  input wire logic frame_lr,
  // frame source
  input wire logic word_valid,
  output logic word_ready,
  input wire sart_pkg::sart_frame_t word,
  // serial side
  output logic sd,
  output logic underrun_evt,
  output logic active
);
  sart_pkg::sart_ser_state_t state, next_state;
  sart_pkg::sart_frame_t cur, next_cur;
  logic [7:0] cnt, next_cnt;
  logic lr_prev, next_lr_prev, next_sd;

  // bit c of the 256-bit tdm8 frame, msb of slot 0 first
  function automatic logic tdm_bit(input sart_pkg::sart_frame_t w, input logic [7:0] c);
    logic [31:0] s;
    case (c[7:5])
      3'd0: s = {w.left_audio, `SART_PAD}; // R7
      3'd1: s = {20'h0, w.left_pvuc, `SART_PAD}; // R8
      3'd2: s = {22'h0, w.compr_type, w.audio_type, `SART_PAD}; // R9
      3'd4: s = {w.right_audio, `SART_PAD}; // R7
      3'd5: s = {20'h0, w.right_pvuc, `SART_PAD}; // R8
      3'd7: s = {23'h0, w.block_start, `SART_PAD}; // R10
      default: s = 32'h0000_0000; // R9
    endcase
    tdm_bit = s[5'd31 - c[4:0]];
  endfunction

  always_comb
  begin
    next_state = state;
    next_cur = cur;
    next_cnt = cnt;
    next_lr_prev = lr_prev;
    next_sd = sd;
    word_ready = 1'b0;
    underrun_evt = 1'b0;
    if (bit_tick)
    begin
      next_lr_prev = frame_lr;
      if (frame_lr && !lr_prev)
      begin
        // an empty fifo at frame start sends a silent frame
        word_ready = word_valid;
        underrun_evt = !word_valid;
        next_cur = word_valid ? word : '0;
        next_cnt = 8'h00;
        next_state = sart_pkg::SER_RUN;
        next_sd = tdm_bit(next_cur, 8'h00);
      end
      else
      begin
        case (state)
          sart_pkg::SER_RUN:
          begin
            if (cnt == `SART_LAST_BIT)
            begin
              next_state = sart_pkg::SER_IDLE;
              next_sd = 1'b0;
            end
            else
            begin
              next_cnt = cnt + 1'b1;
              next_sd = tdm_bit(cur, next_cnt);
            end
          end
          default: next_sd = 1'b0;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state <= sart_pkg::SER_IDLE;
      cur <= '0;
      cnt <= 8'h00;
      lr_prev <= 1'b0;
      sd <= 1'b0;
    end
    else if (ce)
    begin
      state <= next_state;
      cur <= next_cur;
      cnt <= next_cnt;
      lr_prev <= next_lr_prev;
      sd <= next_sd;
    end
  end

  assign active = (state == sart_pkg::SER_RUN);

  a_slot_padding: assert property (@(posedge sys_clk) disable iff (!resetn) // R7
    (ce && bit_tick && state == sart_pkg::SER_RUN && !(frame_lr && !lr_prev)
      && cnt != `SART_LAST_BIT && cnt[4:0] >= 5'd23 && cnt[4:0] <= 5'd30) |=> (sd == 1'b0))
    else $error("padding bit of a slot is not zero");

  a_slot3_silent: assert property (@(posedge sys_clk) disable iff (!resetn) // R9
    (ce && state == sart_pkg::SER_RUN && (cnt[7:5] == 3'd3 || cnt[7:5] == 3'd6)) |-> (sd == 1'b0))
    else $error("slot 3 or 6 carries a one");

  a_status_lead: assert property (@(posedge sys_clk) disable iff (!resetn) // R8
    (ce && state == sart_pkg::SER_RUN && cnt[7:5] == 3'd1 && cnt[4:0] < 5'd20) |-> (sd == 1'b0))
    else $error("leading zeros of slot 1 broken");

  a_block_slot: assert property (@(posedge sys_clk) disable iff (!resetn) // R10
    (ce && state == sart_pkg::SER_RUN && cnt[7:5] == 3'd7 && cnt[4:0] == 5'd23)
      |-> (sd == cur.block_start))
    else $error("block start bit misplaced");

  c_frame_run: cover property (@(posedge sys_clk) disable iff (!resetn)
    word_ready ##1 (state == sart_pkg::SER_RUN));
endmodule
`default_nettype wire

// ==== core/sart_route.sv ====
// How it works
// [R1] Software must set the chosen serial output port as clock master so it drives its clocks.
// [R2] With the clock-source bit at 0 the chosen port's bit and frame clocks follow the recovered receiver clocks.
// [R3] With the clock-source bit (bit 4) at 1 the chosen port is clocked from the third clock generator.
// [R4] Software must set that generator's reference field to 1110 and its source bit to 1 before choosing it.
// [R5] The one-hot select field 0001, 0010, 0100, 1000 routes the stream to serial output 0, 1, 2 or 3.
// [R6] A select field of 0000, the reset value, sends the stream to no output at all.
// [R7] Slots 0 and 4 carry the 24 left or right audio bits and then eight zeros.
// [R8] Slots 1 and 5 carry 20 zeros, parity, validity, user and status bits, then eight zeros.
// [R9] Slot 2 carries 22 zeros, compression type, audio type, eight zeros; slots 3 and 6 are zero.
// [R10] Slot 7 carries 23 zeros, the block-start bit and eight zeros.
`timescale 1ns/1ps
`default_nettype none
`include "sart_map.svh"
module sart_route
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic ce,
  // wishbone register slave
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  // decoded receiver stream, one word per frame
  input wire logic rx_valid,
  output logic rx_ready,
  input wire logic [23:0] rx_left_audio,
  input wire logic [23:0] rx_right_audio,
  input wire logic [3:0] rx_left_pvuc,
  input wire logic [3:0] rx_right_pvuc,
  input wire logic rx_compr_type,
  input wire logic rx_audio_type,
  input wire logic rx_block_start,
  // clock sources
  input wire logic rx_bclk,
  input wire logic rx_lrclk,
  input wire logic gen3_bclk,
  input wire logic gen3_lrclk,
  // serial output ports
  output logic [3:0] serial_data_output_n,
  output logic [3:0] serial_bit_clock_output_n,
  output logic [3:0] serial_frame_clock_output_n
);
  logic [15:0] receiver_aux_tdm_route, next_route;
  logic underrun, next_underrun;
  logic ack, next_ack;
  logic [31:0] rdat, next_rdat;
  logic req, wr_route, wr_status;
  logic [3:0] aux_stream_port_select;
  logic aux_stream_clock_source;
  logic sel_bclk, sel_lrclk, bclk_q, next_bclk_q, lrclk_q, next_lrclk_q, bit_tick;
  logic [3:0] port_en, next_sdo, next_bco, next_fco;
  sart_pkg::sart_frame_t in_word, out_word;
  logic out_valid, out_ready, ser_sd, underrun_evt, ser_active;
  logic [4:0] level;

  assign aux_stream_port_select = receiver_aux_tdm_route[`SART_SEL_MSB:`SART_SEL_LSB];
  assign aux_stream_clock_source = receiver_aux_tdm_route[`SART_SRC_BIT];

  // register slave: ack one cycle after the request, unmapped reads give zero
  always_comb
  begin
    req = wb_cyc_i & wb_stb_i & ~ack;
    wr_route = req & wb_we_i & (wb_adr_i == `SART_ADR_ROUTE);
    wr_status = req & wb_we_i & (wb_adr_i == `SART_ADR_STATUS);
    next_ack = req;
    next_route = receiver_aux_tdm_route;
    if (wr_route && wb_sel_i[0])
      next_route[7:0] = wb_dat_i[7:0];
    if (wr_route && wb_sel_i[1])
      next_route[15:8] = wb_dat_i[15:8];
    // a new underrun wins over a clear in the same cycle
    next_underrun = underrun_evt |
      (underrun & ~(wr_status & wb_sel_i[1] & wb_dat_i[`SART_ST_UNDERRUN]));
    next_rdat = rdat;
    if (req && !wb_we_i)
    begin
      case (wb_adr_i)
        `SART_ADR_ROUTE: next_rdat = {16'h0000, receiver_aux_tdm_route};
        `SART_ADR_STATUS: next_rdat = {22'h00_0000, ser_active, underrun, 3'h0, level};
        default: next_rdat = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      receiver_aux_tdm_route <= `SART_ROUTE_RST; // R6
      underrun <= 1'b0;
      ack <= 1'b0;
      rdat <= 32'h0000_0000;
    end
    else if (ce)
    begin
      receiver_aux_tdm_route <= next_route;
      underrun <= next_underrun;
      ack <= next_ack;
      rdat <= next_rdat;
    end
  end

  assign wb_ack_o = ack;
  assign wb_dat_o = rdat;

  // clock source select; both sources are sampled as synchronous levels
  always_comb
  begin
    sel_bclk = aux_stream_clock_source ? gen3_bclk : rx_bclk; // R3
    sel_lrclk = aux_stream_clock_source ? gen3_lrclk : rx_lrclk; // R2
    next_bclk_q = sel_bclk;
    next_lrclk_q = sel_lrclk;
    bit_tick = bclk_q & ~sel_bclk;
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      bclk_q <= 1'b0;
      lrclk_q <= 1'b0;
    end
    else if (ce)
    begin
      bclk_q <= next_bclk_q;
      lrclk_q <= next_lrclk_q;
    end
  end

  assign in_word = '{left_audio: rx_left_audio, right_audio: rx_right_audio,
    left_pvuc: rx_left_pvuc, right_pvuc: rx_right_pvuc, compr_type: rx_compr_type,
    audio_type: rx_audio_type, block_start: rx_block_start};

  sart_fifo #(.W(`SART_FRAME_W), .D(`SART_FIFO_DEPTH)) u_fifo
  (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .ce(ce),
    .in_valid(rx_valid),
    .in_ready(rx_ready),
    .in_data(in_word),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(out_word),
    .level(level)
  );

  sart_tdm_ser u_ser
  (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .ce(ce),
    .bit_tick(bit_tick),
    .frame_lr(lrclk_q),
    .word_valid(out_valid),
    .word_ready(out_ready),
    .word(out_word),
    .sd(ser_sd),
    .underrun_evt(underrun_evt),
    .active(ser_active)
  );

  // per-port routing; non one-hot codes other than the listed ones drive nothing
  genvar gi;
  generate
    for (gi = 0; gi < `SART_PORTS; gi++)
    begin : g_port
      assign port_en[gi] = (aux_stream_port_select == 4'(1 << gi)); // R5
      assign next_sdo[gi] = port_en[gi] & ser_sd; // R6
      assign next_bco[gi] = port_en[gi] & sel_bclk; // R2
      assign next_fco[gi] = port_en[gi] & sel_lrclk; // R3
    end
  endgenerate

  // the port acts as clock master here, driving its own clocks
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      serial_data_output_n <= 4'h0;
      serial_bit_clock_output_n <= 4'h0;
      serial_frame_clock_output_n <= 4'h0;
    end
    else if (ce)
    begin
      serial_data_output_n <= next_sdo; // R1
      serial_bit_clock_output_n <= next_bco;
      serial_frame_clock_output_n <= next_fco;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  a_ack_single: assert property (ack |=> !ack)
    else $error("ack held longer than one cycle");

  a_ack_follows: assert property ((ce && wb_cyc_i && wb_stb_i && !ack) |=> ack)
    else $error("request not acknowledged next cycle");

  a_route_off_quiet: assert property ( // R6
    (ce && aux_stream_port_select == `SART_SEL_OFF)[*2] |->
      (serial_data_output_n == 4'h0 && serial_bit_clock_output_n == 4'h0
      && serial_frame_clock_output_n == 4'h0))
    else $error("output active while routing is off");

  a_onehot_port2: assert property ( // R5
    (ce && aux_stream_port_select == 4'b0100) |=>
      (serial_data_output_n[2] == $past(ser_sd) && serial_data_output_n[0] == 1'b0
      && serial_bit_clock_output_n[3] == 1'b0))
    else $error("port 2 selection not honoured");

  a_src_recovered: assert property ( // R2
    (ce && !aux_stream_clock_source && aux_stream_port_select == 4'b0001) |=>
      (serial_bit_clock_output_n[0] == $past(rx_bclk)
      && serial_frame_clock_output_n[0] == $past(rx_lrclk)))
    else $error("recovered clocks not on port 0");

  a_src_generator: assert property ( // R3
    (ce && aux_stream_clock_source && aux_stream_port_select == 4'b1000) |=>
      (serial_bit_clock_output_n[3] == $past(gen3_bclk)
      && serial_frame_clock_output_n[3] == $past(gen3_lrclk)))
    else $error("generator clocks not on port 3");

  a_underrun_sticky: assert property ((ce && underrun_evt) |=> underrun[*2])
    else $error("underrun flag lost");

  a_underrun_clear: assert property (
    (ce && wr_status && wb_sel_i[1] && wb_dat_i[`SART_ST_UNDERRUN] && !underrun_evt)
      |=> !underrun)
    else $error("underrun flag not cleared");

  a_ack_no_request: assert property ((ce && !(wb_cyc_i && wb_stb_i)) |=> !ack)
    else $error("ack without a request");

  a_route_low_byte: assert property ( // R5
    (ce && wr_route && wb_sel_i[0]) |=>
      (receiver_aux_tdm_route[7:0] == $past(wb_dat_i[7:0])))
    else $error("route low byte not written");

  a_route_high_byte: assert property (
    (ce && wr_route && wb_sel_i[1]) |=>
      (receiver_aux_tdm_route[15:8] == $past(wb_dat_i[15:8])))
    else $error("route high byte not written");

  a_route_readback: assert property ( // R6
    (ce && req && !wb_we_i && wb_adr_i == `SART_ADR_ROUTE) |=>
      (wb_dat_o == {16'h0000, $past(receiver_aux_tdm_route)}))
    else $error("route read data wrong");

  a_status_readback: assert property (
    (ce && req && !wb_we_i && wb_adr_i == `SART_ADR_STATUS) |=>
      (wb_dat_o[4:0] == $past(level) && wb_dat_o[8] == $past(underrun)
      && wb_dat_o[9] == $past(ser_active)))
    else $error("status read data wrong");

  a_unmapped_zero: assert property (
    (ce && req && !wb_we_i && wb_adr_i != `SART_ADR_ROUTE
      && wb_adr_i != `SART_ADR_STATUS) |=> (wb_dat_o == 32'h0000_0000))
    else $error("unmapped read not zero");

  a_foreign_write: assert property (
    (ce && req && wb_we_i && wb_adr_i != `SART_ADR_ROUTE) |=>
      $stable(receiver_aux_tdm_route))
    else $error("route changed by a foreign write");

  a_odd_code_quiet: assert property ( // R6
    (ce && !$onehot(aux_stream_port_select)) |=>
      (serial_data_output_n == 4'h0 && serial_bit_clock_output_n == 4'h0
      && serial_frame_clock_output_n == 4'h0))
    else $error("output active on a disabled code");

  a_port1_select: assert property ( // R5
    (ce && aux_stream_port_select == 4'b0010) |=>
      (serial_data_output_n[1] == $past(ser_sd)
      && serial_bit_clock_output_n[1] == $past(sel_bclk)
      && serial_frame_clock_output_n[1] == $past(sel_lrclk)
      && serial_data_output_n[3] == 1'b0))
    else $error("port 1 selection not honoured");

  a_port0_data: assert property ( // R5
    (ce && aux_stream_port_select == 4'b0001) |=>
      (serial_data_output_n[0] == $past(ser_sd) && serial_bit_clock_output_n[1] == 1'b0))
    else $error("port 0 data not routed");

  c_port3_gen: cover property (aux_stream_clock_source && port_en[3] && ser_active);
  c_port0_rec: cover property (!aux_stream_clock_source && port_en[0] && out_ready);
  c_underrun: cover property (underrun_evt ##1 underrun);
endmodule
`default_nettype wire

// ==== tb/sart_listener.sv ====
`timescale 1ns/1ps
`default_nettype none
module sart_listener
(
  // clock and chosen port
  input wire logic sys_clk,
  input wire logic [1:0] port,
  // serial output pins
  input wire logic [3:0] sd,
  input wire logic [3:0] bck,
  input wire logic [3:0] fck,
  // last whole frame
  output logic [255:0] frame,
  output int unsigned n_frames
);
  logic pb = 1'b0;
  logic pf = 1'b0;
  logic [1:0] pp = 2'd0;
  logic [255:0] sh = '0;
  int unsigned nb = 0;
  initial
  begin
    frame = '0;
    n_frames = 0;
  end
  // slave only: both clocks come from the chosen port, never from us
  always @(posedge sys_clk)
  begin
    if (port != pp)
      nb = 0;
    if (bck[port] && !pb)
    begin
      // bit 0 follows the bit in which the frame clock is first seen high
      if (nb != 0)
      begin
        sh = {sh[254:0], sd[port]};
        nb = nb + 1;
      end
      if (nb == 257)
      begin
        frame = sh;
        n_frames = n_frames + 1;
        nb = 0;
      end
      if (fck[port] && !pf)
        nb = 1;
      pf = fck[port];
    end
    pb = bck[port];
    pp = port;
  end
endmodule
`default_nettype wire

// ==== tb/tb_spdif_rx_aux_tdm_route.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_spdif_rx_aux_tdm_route;
  typedef struct packed {logic [15:0] rt; logic on; logic [1:0] pt;} sart_row_t;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] wb_adr_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [3:0] wb_sel_i = 4'hf;
  logic wb_we_i = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_ack_o;
  logic [31:0] wb_dat_o;
  logic rx_valid = 1'b0;
  logic rx_ready;
  sart_pkg::sart_frame_t w = '0;
  logic [9:0] cnt = 10'h000;
  logic [9:0] g;
  logic gs = 1'b0;
  logic sb_d = 1'b0;
  logic fb_d = 1'b0;
  logic [3:0] sdo, bco, fco;
  logic [1:0] lport = 2'd0;
  logic [255:0] lframe;
  int unsigned lcount;
  logic [31:0] rd;
  int n_fail = 0;
  int checks = 0;
  sart_row_t rows [8] = '{'{16'h0001, 1'b1, 2'd0}, '{16'h0002, 1'b1, 2'd1},
    '{16'h0004, 1'b1, 2'd2}, '{16'h0008, 1'b1, 2'd3}, '{16'h0011, 1'b1, 2'd0},
    '{16'h0018, 1'b1, 2'd3}, '{16'h0000, 1'b0, 2'd0}, '{16'hffe3, 1'b0, 2'd0}};

  always #25 sys_clk = ~sys_clk;
  // generator clocks run half a frame and half a bit away from the recovered ones
  assign g = cnt + 10'h202;
  always @(posedge sys_clk)
  begin
    cnt <= cnt + 10'h001;
    sb_d <= gs ? g[1] : cnt[1];
    fb_d <= gs ? (g[9:2] == 8'h00) : (cnt[9:2] == 8'h00);
  end

  sart_route dut (.sys_clk(sys_clk), .resetn(resetn), .ce(1'b1), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_left_audio(w.left_audio), .rx_right_audio(w.right_audio),
    .rx_left_pvuc(w.left_pvuc), .rx_right_pvuc(w.right_pvuc), .rx_compr_type(w.compr_type),
    .rx_audio_type(w.audio_type), .rx_block_start(w.block_start), .rx_bclk(cnt[1]),
    .rx_lrclk(cnt[9:2] == 8'h00), .gen3_bclk(g[1]), .gen3_lrclk(g[9:2] == 8'h00),
    .serial_data_output_n(sdo), .serial_bit_clock_output_n(bco),
    .serial_frame_clock_output_n(fco));
  sart_listener lsn (.sys_clk(sys_clk), .port(lport), .sd(sdo), .bck(bco), .fck(fco),
    .frame(lframe), .n_frames(lcount));

  function automatic logic [255:0] tdm(input sart_pkg::sart_frame_t f);
    return {f.left_audio, 8'h00, 20'h0_0000, f.left_pvuc, 8'h00, 22'h00_0000, f.compr_type,
      f.audio_type, 8'h00, 32'h0000_0000, f.right_audio, 8'h00, 20'h0_0000, f.right_pvuc,
      8'h00, 32'h0000_0000, 23'h00_0000, f.block_start, 8'h00};
  endfunction
  task automatic chk(input string nm, input logic [255:0] e, input logic [255:0] s);
    checks++;
    if (s !== e)
    begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic hang(input string nm);
    n_fail++;
    $display("BAD %s timed out", nm);
    tally_and_finish();
  endtask
  task automatic tally_and_finish();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wb(input logic [3:0] a, input logic we, input logic [31:0] d);
    int i;
    @(posedge sys_clk);
    wb_adr_i <= a;
    wb_we_i <= we;
    wb_dat_i <= d;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    for (i = 0; i < 20; i++)
    begin
      @(posedge sys_clk);
      if (wb_ack_o === 1'b1)
        break;
    end
    if (i == 20)
      hang("ack");
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask
  task automatic wait_idx(input logic [9:0] v, input logic gen);
    int i;
    for (i = 0; i < 1100; i++)
    begin
      @(posedge sys_clk);
      if ((gen ? g : cnt) == v)
        break;
    end
    if (i == 1100)
      hang("frame phase");
  endtask
  task automatic wait_frame();
    int i;
    int unsigned n;
    n = lcount;
    for (i = 0; i < 2200 && lcount == n; i++)
      @(posedge sys_clk);
    if (i == 2200)
      hang("frame");
  endtask

  initial
  begin
    int r, k, n;
    logic [11:0] any;
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    wb(4'h0, 1'b0, 32'h0000_0000);
    chk("route_reset", '0, 256'(rd));
    chk("pins_reset", '0, 256'({sdo, bco, fco}));
    for (r = 0; r < 8; r++)
    begin
      lport <= rows[r].pt;
      // generator setup is assumed done by software before the gen rows
      wb(4'h0, 1'b1, {16'h0000, rows[r].rt});
      wb(4'h0, 1'b0, 32'h0000_0000);
      chk("route_rb", 256'(rows[r].rt), 256'(rd));
      if (rows[r].on)
      begin
        gs <= rows[r].rt[4];
        w <= {8'(r), 16'ha5c3, 8'(r), 16'h3c5a, 4'(r), ~4'(r), r[0], ~r[0], r[1]};
        // let the serializer resync to the new clock before the word goes in
        wait_idx(10'h200, rows[r].rt[4]);
        wait_idx(10'h200, rows[r].rt[4]);
        rx_valid <= 1'b1;
        @(posedge sys_clk);
        rx_valid <= 1'b0;
        wait_idx(10'h00a, rows[r].rt[4]);
        wait_frame();
        chk("frame", tdm(w), lframe);
        for (k = 0; k < 8; k++)
        begin
          @(posedge sys_clk);
          chk("clk_pins", 256'({4'(sb_d) << rows[r].pt, 4'(fb_d) << rows[r].pt}),
            256'({bco, fco}));
        end
      end
      else
      begin
        any = '0;
        for (k = 0; k < 1100; k++)
        begin
          @(posedge sys_clk);
          any = any | {sdo, bco, fco};
        end
        chk("off_pins", '0, 256'(any));
      end
    end
    // fill the fifo between frame starts so nothing is popped meanwhile
    wait_idx(10'h200, 1'b0);
    rx_valid <= 1'b1;
    n = 0;
    for (k = 0; k < 40 && rx_ready !== 1'b0; k++)
    begin
      @(posedge sys_clk);
      if (rx_ready === 1'b1)
        n++;
    end
    rx_valid <= 1'b0;
    chk("accepted", 256'(16), 256'(n));
    wb(4'h4, 1'b0, 32'h0000_0000);
    chk("level_full", 256'(5'h10), 256'(rd[4:0]));
    // the fifo is full, so nothing can set the flag again before the drain
    wb(4'h4, 1'b1, 32'h0000_0100);
    wb(4'h4, 1'b0, 32'h0000_0000);
    chk("underrun_pre", '0, 256'(rd[8]));
    lport <= 2'd0;
    wb(4'h0, 1'b1, 32'h0000_0001);
    for (k = 0; k < 20; k++)
    begin
      wait_frame();
      wb(4'h4, 1'b0, 32'h0000_0000);
      if (rd[4:0] == 5'h00)
        break;
    end
    if (k == 20)
      hang("drain");
    wait_frame();
    wait_frame();
    chk("empty_frame", '0, lframe);
    wb(4'h4, 1'b0, 32'h0000_0000);
    chk("underrun", 256'(1'b1), 256'(rd[8]));
    wait_idx(10'h200, 1'b0);
    wb(4'h4, 1'b1, 32'h0000_0100);
    wb(4'h4, 1'b0, 32'h0000_0000);
    chk("underrun_clr", '0, 256'(rd[8]));
    wb(4'h8, 1'b1, 32'h0000_0000);
    wb(4'h8, 1'b0, 32'h0000_0000);
    chk("unmapped", '0, 256'(rd));
    wb(4'h0, 1'b0, 32'h0000_0000);
    chk("route_kept", 256'(16'h0001), 256'(rd));
    resetn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk("pins_rerst", '0, 256'({sdo, bco, fco}));
    resetn <= 1'b1;
    wb(4'h0, 1'b0, 32'h0000_0000);
    chk("route_rerst", '0, 256'(rd));
    tally_and_finish();
  end
endmodule
`default_nettype wire
